// File: hw/reader_operation_mode_control.sv
// Operation control and mode definition registers on an AHB-Lite slave.
// Assumes rst is the power-up reset; commands arrive as one-cycle pulses.
//
// Contract
// - Bit 7 of operation control turns oscillator and regulator on (ready) or off.
// - The receive path is active only while receive_enable is one.
// - Bit 5 zero runs both AM and PM channels; one runs one channel chosen by demod_path_choice.
// - With both channels on, bit 4 zero selects automatically, one follows demod_path_choice; here bit 4 one only clears channel_auto_select.
// - Bit 3 enables transmit; field-on sets it and a finished peer-to-peer transmit clears it.
// - Bit 2 places the device in wake-up mode governed by the wake-up timer settings.
// - Operation control resets to zero only at power-up, not on other reset commands.
// - Mode bit 7 picks initiator or target and bits 6..3 decode per role.
// - Initiator codes 0,1,2,3,4,e,f map to the seven initiator protocols.
// - Target code 1 is active peer-to-peer normal mode.
// - Target code 0 is active peer-to-peer with bit rate detection.
// - An unsupported role and code blocks all transmit and receive.
// - With mode bit 0 set, external field off starts response collision avoidance.
// - Mode register defaults (initiator, code 1, auto off) at power-up and set-default.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module reader_operation_mode_control (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Device commands and events
   input  wire logic        cmd_set_default,
   input  wire logic        cmd_field_on,
   input  wire logic        p2p_tx_done,
   input  wire logic        field_present,
   input  wire logic        demod_path_choice,
   // Controlled functions
   output logic             osc_reg_enable,
   output logic             rx_active,
   output logic             am_channel_on,
   output logic             pm_channel_on,
   output logic             channel_auto_select,
   output logic             tx_active,
   output logic             wakeup_mode,
   output logic             ca_start,
   output opmode_pkg::proto_e proto_sel
);
   import opmode_pkg::*;

   typedef struct packed {
      logic [7:0]  opc;
      logic [7:0]  mode;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic        osc;
      logic        rx;
      logic        am;
      logic        pm;
      logic        autosel;
      logic        tx;
      logic        wu;
   } bank_s;

   bank_s st_ff;
   bank_s nxt_st;
   logic  ca_pulse;
   opmode_if m ();

   function automatic logic [31:0] read_word(input logic [7:0] a, input logic [7:0] opc,
                                             input logic [7:0] mode, input logic ok);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         ADDR_OPERATION_CONTROL: r = {24'h00_0000, opc & OPC_USED_MASK};
         ADDR_MODE_DEFINITION:   r = {24'h00_0000, mode & MODE_USED_MASK};
         ADDR_STATUS:            r = {31'h0000_0000, ok};
         default:                r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   assign m.mode_reg = st_ff.mode;

   mode_decoder u_dec (
      .m (m)
   );

   ca_starter u_ca (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .enable        (st_ff.mode[MODE_AUTO_CA]),
      .field_present (field_present),
      .start         (ca_pulse)
   );

   logic addr_phase;
   logic p2p_mode;
   assign addr_phase = hsel & hready & htrans[1];
   assign p2p_mode   = (m.proto == PROTO_INI_P2P) | (m.proto == PROTO_TGT_NORMAL)
                     | (m.proto == PROTO_TGT_RATE_DET);

   always_comb begin
      nxt_st = st_ff;
      if (addr_phase) begin
         nxt_st.wr_pend = hwrite;
         nxt_st.wr_addr = {haddr[7:2], 2'b00};
         nxt_st.rdata   = hwrite ? 32'h0000_0000
                                 : read_word({haddr[7:2], 2'b00}, st_ff.opc, st_ff.mode,
                                             m.supported);
      end else if (hready) begin
         nxt_st.wr_pend = 1'b0;
      end
      if (st_ff.wr_pend) begin
         case (st_ff.wr_addr)
            ADDR_OPERATION_CONTROL: nxt_st.opc = hwdata[7:0] & OPC_USED_MASK;
            ADDR_MODE_DEFINITION:   nxt_st.mode = hwdata[7:0] & MODE_USED_MASK;
            default: ;
         endcase
      end
      // Hardware events win over a software write in the same cycle
      if (cmd_field_on) begin
         nxt_st.opc[OPC_TX_EN] = 1'b1;
      end else if (p2p_tx_done && p2p_mode) begin
         nxt_st.opc[OPC_TX_EN] = 1'b0;
      end
      if (cmd_set_default) begin
         nxt_st.mode = MODE_RESET;
      end
      nxt_st.osc     = st_ff.opc[OPC_OSC_EN];
      nxt_st.rx      = st_ff.opc[OPC_RX_EN] & m.supported;
      nxt_st.am      = nxt_st.rx & (~st_ff.opc[OPC_RX_SINGLE] | ~demod_path_choice);
      nxt_st.pm      = nxt_st.rx & (~st_ff.opc[OPC_RX_SINGLE] | demod_path_choice);
      nxt_st.autosel = nxt_st.rx & ~st_ff.opc[OPC_RX_SINGLE]
                     & ~st_ff.opc[OPC_RX_MANUAL];
      nxt_st.tx      = st_ff.opc[OPC_TX_EN] & m.supported;
      nxt_st.wu      = st_ff.opc[OPC_WAKEUP];
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff      <= '0;
         st_ff.opc  <= OPC_RESET;
         st_ff.mode <= MODE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hrdata              = st_ff.rdata;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign osc_reg_enable      = st_ff.osc;
   assign rx_active           = st_ff.rx;
   assign am_channel_on       = st_ff.am;
   assign pm_channel_on       = st_ff.pm;
   assign channel_auto_select = st_ff.autosel;
   assign tx_active           = st_ff.tx;
   assign wakeup_mode         = st_ff.wu;
   assign ca_start            = ca_pulse;
   assign proto_sel           = m.proto;
endmodule
`default_nettype wire

// File: hw/opmode_pkg.sv
// Constants for the reader operation and mode control registers.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package opmode_pkg;
   // Register indexes; each register is one word, so the byte address is four times the index
   localparam logic [7:0] IDX_OPERATION_CONTROL  = 8'h02;
   localparam logic [7:0] IDX_MODE_DEFINITION    = 8'h03;
   localparam logic [7:0] ADDR_OPERATION_CONTROL = IDX_OPERATION_CONTROL << 2;
   localparam logic [7:0] ADDR_MODE_DEFINITION   = IDX_MODE_DEFINITION << 2;
   localparam logic [7:0] ADDR_EVENT_CONTROL     = 8'h10;
   localparam logic [7:0] ADDR_STATUS            = 8'h14;
   localparam int OPC_OSC_EN    = 7;
   localparam int OPC_RX_EN     = 6;
   localparam int OPC_RX_SINGLE = 5;
   localparam int OPC_RX_MANUAL = 4;
   localparam int OPC_TX_EN     = 3;
   localparam int OPC_WAKEUP    = 2;
   localparam int MODE_ROLE     = 7;
   localparam int MODE_PROTO_HI = 6;
   localparam int MODE_PROTO_LO = 3;
   localparam int MODE_AUTO_CA  = 0;
   localparam logic [7:0] OPC_USED_MASK  = 8'hfc;
   localparam logic [7:0] MODE_USED_MASK = 8'hf9;
   localparam logic [7:0] OPC_RESET      = 8'h00;
   localparam logic [7:0] MODE_RESET     = 8'h08;
   localparam logic [3:0] P_INI_P2P      = 4'h0;
   localparam logic [3:0] P_INI_14443A   = 4'h1;
   localparam logic [3:0] P_INI_14443B   = 4'h2;
   localparam logic [3:0] P_INI_PROP     = 4'h3;
   localparam logic [3:0] P_INI_T1T      = 4'h4;
   localparam logic [3:0] P_INI_SUBC     = 4'he;
   localparam logic [3:0] P_INI_BPSK     = 4'hf;
   localparam logic [3:0] P_TGT_RATE_DET = 4'h0;
   localparam logic [3:0] P_TGT_NORMAL   = 4'h1;
   typedef enum logic [3:0] {
      PROTO_NONE, PROTO_INI_P2P, PROTO_INI_14443A, PROTO_INI_14443B, PROTO_INI_PROP,
      PROTO_INI_T1T, PROTO_INI_SUBC, PROTO_INI_BPSK, PROTO_TGT_RATE_DET, PROTO_TGT_NORMAL
   } proto_e;
endpackage

// File: hw/opmode_if.sv
// Register values and decoded mode passed between the register bank and its decoders.
// Assumes the opmode package is compiled first.
`timescale 1ns/100ps
`default_nettype none
interface opmode_if;
   import opmode_pkg::*;
   logic [7:0] mode_reg;
   proto_e     proto;
   logic       supported;
   modport bank (output mode_reg, input proto, input supported);
   modport dec  (input mode_reg, output proto, output supported);
endinterface
`default_nettype wire

// File: hw/mode_decoder.sv
// Decodes the role and protocol field of the mode register.
// Assumes the register bank drives mode_reg from flip-flops.
`timescale 1ns/100ps
`default_nettype none
module mode_decoder (
   // Mode register and decode
   opmode_if.dec m
);
   import opmode_pkg::*;
   always_comb begin
      m.proto = PROTO_NONE;
      if (!m.mode_reg[MODE_ROLE]) begin
         case (m.mode_reg[MODE_PROTO_HI:MODE_PROTO_LO])
            P_INI_P2P:    m.proto = PROTO_INI_P2P;
            P_INI_14443A: m.proto = PROTO_INI_14443A;
            P_INI_14443B: m.proto = PROTO_INI_14443B;
            P_INI_PROP:   m.proto = PROTO_INI_PROP;
            P_INI_T1T:    m.proto = PROTO_INI_T1T;
            P_INI_SUBC:   m.proto = PROTO_INI_SUBC;
            P_INI_BPSK:   m.proto = PROTO_INI_BPSK;
            default:      m.proto = PROTO_NONE;
         endcase
      end else begin
         case (m.mode_reg[MODE_PROTO_HI:MODE_PROTO_LO])
            P_TGT_RATE_DET: m.proto = PROTO_TGT_RATE_DET;
            P_TGT_NORMAL:   m.proto = PROTO_TGT_NORMAL;
            default:        m.proto = PROTO_NONE;
         endcase
      end
      m.supported = (m.proto != PROTO_NONE);
   end
endmodule
`default_nettype wire

// File: hw/ca_starter.sv
// Starts response collision avoidance on a falling external field.
// Assumes field_present is synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ca_starter (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Control
   input  wire logic enable,
   input  wire logic field_present,
   output logic      start
);
   typedef struct packed {
      logic field_d;
      logic start;
   } ca_s;
   ca_s st_ff;
   ca_s nxt_st;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.field_d = field_present;
      nxt_st.start = enable & st_ff.field_d & ~field_present;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign start = st_ff.start;
endmodule
`default_nettype wire

// File: testbench/ahb_host.sv
// Host controller model issuing single AHB-Lite word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
`default_nettype none
module ahb_host (
   // Bus
   input  wire logic        clk_sys,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [7:0]  haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_sys);
      hsel   <= 1'h1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'h1);
      q = hrdata;
      // Released data lines must not keep the last value
      hwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// File: testbench/reader_operation_mode_control_chk.sv
// Concurrent checks on the control register block's outputs.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module reader_operation_mode_control_chk
   import opmode_pkg::*;
(
   // Clock and reset
   input wire logic   clk_sys,
   input wire logic   rst,
   // Commands and outputs
   input wire logic   cmd_set_default,
   input wire logic   cmd_field_on,
   input wire logic   p2p_tx_done,
   input wire logic   field_present,
   input wire logic   osc_reg_enable,
   input wire logic   rx_active,
   input wire logic   am_channel_on,
   input wire logic   pm_channel_on,
   input wire logic   channel_auto_select,
   input wire logic   tx_active,
   input wire logic   ca_start,
   input wire proto_e proto_sel
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_RX_GATE: assert property (rx_active |-> $past(proto_sel) != PROTO_NONE)
      else $error("rx active in unsupported mode");
   AST_TX_GATE: assert property (tx_active |-> $past(proto_sel) != PROTO_NONE)
      else $error("tx active in unsupported mode");
   AST_CHAN: assert property (channel_auto_select |-> am_channel_on && pm_channel_on)
      else $error("auto select without both channels");
   AST_CA_PULSE: assert property (ca_start |=> !ca_start)
      else $error("collision avoidance start too long");
   AST_CA_CAUSE: assert property (ca_start |-> !$past(field_present))
      else $error("collision avoidance start with field present");
   AST_MODE_DEF: assert property (cmd_set_default |=> proto_sel == PROTO_INI_14443A)
      else $error("set default did not restore mode");
   AST_FIELD_ON: assert property ((cmd_field_on && proto_sel != PROTO_NONE) ##1
      !p2p_tx_done |=> tx_active) else $error("field on did not enable tx");
   AST_OPC_KEEP: assert property (osc_reg_enable && cmd_set_default |=> osc_reg_enable [*2])
      else $error("set default touched operation control");
   cover property (ca_start);
   cover property (channel_auto_select);
   cover property (tx_active && osc_reg_enable);
endmodule
bind reader_operation_mode_control reader_operation_mode_control_chk chk (.*);
`default_nettype wire

// File: testbench/reader_operation_mode_control_tb.sv
// Self-checking bench for the operation and mode control registers.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module reader_operation_mode_control_tb;
   import opmode_pkg::*;
   logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, ca_start, wakeup_mode;
   logic        cmd_set_default, cmd_field_on, p2p_tx_done, field_present, demod_path_choice;
   logic        osc_reg_enable, rx_active, am_channel_on, pm_channel_on;
   logic        channel_auto_select, tx_active;
   logic [7:0]  haddr, mv[11];
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, q;
   proto_e      proto_sel, pe[11];
   int          bad_count, checked, hits;
   ahb_host host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   reader_operation_mode_control dut (.*, .hready(hreadyout));
   always #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(a, 1'h1, d, q);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(a, 1'h0, 32'h0, q);
      chk(q, exp);
      chk(32'({hreadyout, hresp}), 32'h2);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_sys);
      {cmd_set_default, cmd_field_on, p2p_tx_done} <= 3'h1 << k;
      @(posedge clk_sys);
      {cmd_set_default, cmd_field_on, p2p_tx_done} <= 3'h0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset;
      rd(ADDR_OPERATION_CONTROL, 32'h0);
      rd(ADDR_MODE_DEFINITION, 32'h8);
      chk(32'(proto_sel), 32'(PROTO_INI_14443A));
   endtask
   task automatic t_opc;
      wr(ADDR_OPERATION_CONTROL, 32'hffffffff);
      rd(ADDR_OPERATION_CONTROL, 32'hfc);
      chk(32'({osc_reg_enable, rx_active, tx_active, wakeup_mode}), 32'hf);
      wr(ADDR_OPERATION_CONTROL, 32'h0);
      chk(32'({osc_reg_enable, rx_active, tx_active, wakeup_mode}), 32'h0);
      wr(8'h10, 32'hffffffff);
      rd(8'h10, 32'h0);
   endtask
   task automatic t_chan;
      demod_path_choice <= 1'h1;
      wr(ADDR_OPERATION_CONTROL, 32'he0);
      chk(32'({am_channel_on, pm_channel_on, channel_auto_select}), 32'h2);
      @(posedge clk_sys);
      demod_path_choice <= 1'h0;
      wr(ADDR_OPERATION_CONTROL, 32'he0);
      chk(32'({am_channel_on, pm_channel_on, channel_auto_select}), 32'h4);
      wr(ADDR_OPERATION_CONTROL, 32'hc0);
      chk(32'({am_channel_on, pm_channel_on, channel_auto_select}), 32'h7);
      wr(ADDR_OPERATION_CONTROL, 32'hd0);
      chk(32'({am_channel_on, pm_channel_on, channel_auto_select}), 32'h6);
   endtask
   task automatic t_modes;
      mv = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h70, 8'h78, 8'h28, 8'h80, 8'h88, 8'h90};
      pe = '{PROTO_INI_P2P, PROTO_INI_14443A, PROTO_INI_14443B, PROTO_INI_PROP,
             PROTO_INI_T1T, PROTO_INI_SUBC, PROTO_INI_BPSK, PROTO_NONE,
             PROTO_TGT_RATE_DET, PROTO_TGT_NORMAL, PROTO_NONE};
      wr(ADDR_OPERATION_CONTROL, 32'h48);
      for (int i = 0; i < 11; i++) begin
         wr(ADDR_MODE_DEFINITION, 32'(mv[i]) | 32'h6);
         chk(32'(proto_sel), 32'(pe[i]));
         chk(32'({rx_active, tx_active}), (pe[i] == PROTO_NONE) ? 32'h0 : 32'h3);
         rd(ADDR_MODE_DEFINITION, 32'(mv[i]));
         rd(ADDR_STATUS, (pe[i] == PROTO_NONE) ? 32'h0 : 32'h1);
      end
   endtask
   task automatic t_cmds;
      wr(ADDR_MODE_DEFINITION, 32'h0);
      wr(ADDR_OPERATION_CONTROL, 32'h80);
      pulse(1);
      rd(ADDR_OPERATION_CONTROL, 32'h88);
      pulse(0);
      chk(32'(tx_active), 32'h0);
      pulse(2);
      rd(ADDR_MODE_DEFINITION, 32'h8);
      rd(ADDR_OPERATION_CONTROL, 32'h80);
      pulse(1);
      pulse(0);
      chk(32'(tx_active), 32'h1);
      wr(ADDR_MODE_DEFINITION, 32'h88);
      pulse(0);
      chk(32'(tx_active), 32'h0);
      wr(ADDR_MODE_DEFINITION, 32'h80);
      pulse(1);
      chk(32'(tx_active), 32'h1);
      pulse(0);
      chk(32'(tx_active), 32'h0);
   endtask
   task automatic fld;
      @(posedge clk_sys);
      field_present <= 1'h1;
      repeat (3) @(posedge clk_sys);
      field_present <= 1'h0;
      hits = 0;
      repeat (6) begin
         @(posedge clk_sys);
         #1;
         if (ca_start === 1'h1) hits++;
      end
   endtask
   task automatic t_ca;
      wr(ADDR_MODE_DEFINITION, 32'h09);
      fld();
      chk(32'(hits), 32'h1);
      wr(ADDR_MODE_DEFINITION, 32'h08);
      fld();
      chk(32'(hits), 32'h0);
   endtask
   task automatic give_verdict;
      $display("TB: %0d mismatches in %0d checks", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {clk_sys, rst, bad_count, checked} = '0;
      rst = 1'h1;
      {cmd_set_default, cmd_field_on, p2p_tx_done, field_present, demod_path_choice} = '0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
      t_reset();
      t_opc();
      t_chan();
      t_modes();
      t_cmds();
      t_ca();
      give_verdict();
   end
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
